/* src/smx_exec.v */
// execution datapath for shift, copy and pointer-indirect load operations
`timescale 1ns/1ps
`include "smx_defs.vh"

module smx_exec (
  input  wire        CLK_SYS,
  input  wire        RST_B,
  input  wire        OP_VALID,
  input  wire [2:0]  OP_CODE,
  input  wire        RESULT_TARGET_SEL,
  input  wire        PTR_SEL,
  input  wire [1:0]  PTR_UPDATE_CODE,
  input  wire [5:0]  SIGNED_OFFSET,
  input  wire [7:0]  FILE_RD_DATA,
  input  wire        PTR_WR_EN,
  input  wire        PTR_WR_IDX,
  input  wire [15:0] PTR_WR_DATA,
  input  wire [7:0]  MEM_RD_DATA,
  output reg  [7:0]  ACC,
  output reg         SHIFT_OUT_FLAG,
  output reg         RESULT_NULL_FLAG,
  output reg         FILE_WR_EN,
  output reg  [7:0]  FILE_WR_DATA,
  output reg         MEM_RD_EN,
  output reg  [15:0] MEM_RD_ADDR,
  output reg  [15:0] POINTER_REG0,
  output reg  [15:0] POINTER_REG1,
  output reg         BUSY
);

  // ****************************************
  // state encoding
  // ****************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg        state_q;
  reg        state_d;
  reg [7:0]  acc_d;
  reg        sof_d;
  reg        rnf_d;
  reg        fwe_d;
  reg [7:0]  fwd_d;
  reg        mre_d;
  reg [15:0] mra_d;
  reg [15:0] p0_d;
  reg [15:0] p1_d;
  reg [7:0]  shl_res;
  reg [7:0]  shr_res;
  reg [15:0] ptr_cur;
  wire [15:0] eff_addr;
  wire [15:0] ptr_next;

  // ****************************************
  // helpers
  // ****************************************
  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00);
    end
  endfunction

  // ****************************************
  // pointer arithmetic
  // ****************************************
  // combinational, so the address is ready in the cycle the load is taken
  smx_ptr_unit u_ptr (
    .ptr_cur  (ptr_cur),
    .rel_form (OP_CODE == `SMX_OP_LOAD_REL),
    .upd_code (PTR_UPDATE_CODE),
    .offset   (SIGNED_OFFSET),
    .eff_addr (eff_addr),
    .ptr_next (ptr_next)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  always @* begin
    // left shift, zero into bit 0
    shl_res = {FILE_RD_DATA[6:0], 1'b0};
    // right shift, zero into bit 7
    shr_res = {1'b0, FILE_RD_DATA[7:1]};
    ptr_cur = PTR_SEL ? POINTER_REG1 : POINTER_REG0;
    state_d = state_q;
    acc_d   = ACC;
    sof_d   = SHIFT_OUT_FLAG;
    rnf_d   = RESULT_NULL_FLAG;
    fwe_d   = 1'b0;
    fwd_d   = FILE_WR_DATA;
    mre_d   = 1'b0;
    mra_d   = MEM_RD_ADDR;
    p0_d    = POINTER_REG0;
    p1_d    = POINTER_REG1;
    // direct pointer writes from the core, dropped while a load is in flight
    // a load through the same pointer in the same cycle overrides the write
    if (PTR_WR_EN && state_q == ST_IDLE) begin
      if (PTR_WR_IDX)
        p1_d = PTR_WR_DATA;
      else
        p0_d = PTR_WR_DATA;
    end
    case (state_q)
      ST_IDLE: begin
        if (OP_VALID) begin
          case (OP_CODE)
            `SMX_OP_SHL: begin
              sof_d = FILE_RD_DATA[`SMX_MSB];
              rnf_d = is_zero(shl_res);
              if (RESULT_TARGET_SEL) begin
                fwe_d = 1'b1;
                fwd_d = shl_res;
              end else begin
                acc_d = shl_res;
              end
            end
            `SMX_OP_SHR: begin
              sof_d = FILE_RD_DATA[`SMX_LSB];
              rnf_d = is_zero(shr_res);
              if (RESULT_TARGET_SEL) begin
                fwe_d = 1'b1;
                fwd_d = shr_res;
              end else begin
                acc_d = shr_res;
              end
            end
            `SMX_OP_COPY: begin
              rnf_d = is_zero(FILE_RD_DATA);
              if (RESULT_TARGET_SEL) begin
                fwe_d = 1'b1;
                fwd_d = FILE_RD_DATA;
              end else begin
                acc_d = FILE_RD_DATA;
              end
            end
            `SMX_OP_LOAD_MOD, `SMX_OP_LOAD_REL: begin
              // indirect access goes to the effective address from the pointer unit
              mre_d = 1'b1;
              mra_d = eff_addr;
              if (PTR_SEL)
                p1_d = ptr_next;
              else
                p0_d = ptr_next;
              state_d = ST_WAIT;
            end
            default: begin
              state_d = ST_IDLE;
            end
          endcase
        end
      end
      ST_WAIT: begin
        // memory must answer in one cycle; there is no wait input
        // loaded byte to accumulator
        acc_d = MEM_RD_DATA;
        rnf_d = is_zero(MEM_RD_DATA);
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always @(posedge CLK_SYS) begin
    if (!RST_B) begin
      state_q          <= ST_IDLE;
      ACC              <= `SMX_ACC_RST;
      SHIFT_OUT_FLAG   <= `SMX_FLAG_RST;
      RESULT_NULL_FLAG <= `SMX_FLAG_RST;
      FILE_WR_EN       <= 1'b0;
      FILE_WR_DATA     <= `SMX_ACC_RST;
      MEM_RD_EN        <= 1'b0;
      MEM_RD_ADDR      <= `SMX_PTR_RST;
      POINTER_REG0     <= `SMX_PTR_RST;
      POINTER_REG1     <= `SMX_PTR_RST;
      BUSY             <= 1'b0;
    end else begin
      state_q          <= state_d;
      ACC              <= acc_d;
      SHIFT_OUT_FLAG   <= sof_d;
      RESULT_NULL_FLAG <= rnf_d;
      FILE_WR_EN       <= fwe_d;
      FILE_WR_DATA     <= fwd_d;
      MEM_RD_EN        <= mre_d;
      MEM_RD_ADDR      <= mra_d;
      POINTER_REG0     <= p0_d;
      POINTER_REG1     <= p1_d;
      // ops are ignored while busy; decoder must wait
      BUSY             <= (state_d == ST_WAIT);
    end
  end

endmodule // smx_exec

/* src/smx_defs.vh */
// constants for the shift / move / indirect-load execution datapath
`ifndef SMX_DEFS_VH
`define SMX_DEFS_VH

// operation codes presented by the decoder
`define SMX_OP_NONE      3'h0
`define SMX_OP_SHL       3'h1
`define SMX_OP_SHR       3'h2
`define SMX_OP_COPY      3'h3
`define SMX_OP_LOAD_MOD  3'h4
`define SMX_OP_LOAD_REL  3'h5

// pointer update codes
`define SMX_PU_PRE_INC   2'h0
`define SMX_PU_PRE_DEC   2'h1
`define SMX_PU_POST_INC  2'h2
`define SMX_PU_POST_DEC  2'h3

// field positions
`define SMX_MSB          3'h7
`define SMX_LSB          3'h0

// reset values
`define SMX_ACC_RST      8'h00
`define SMX_PTR_RST      16'h0000
`define SMX_FLAG_RST     1'b0

// memory read latency in clock cycles (address to data)
`define SMX_RD_LAT       1

`endif

/* src/smx_ptr_unit.v */
// pointer address and update arithmetic for the indirect load
`timescale 1ns/1ps
`include "smx_defs.vh"

module smx_ptr_unit (
  input  wire [15:0] ptr_cur,
  input  wire        rel_form,
  input  wire [1:0]  upd_code,
  input  wire [5:0]  offset,
  output reg  [15:0] eff_addr,
  output reg  [15:0] ptr_next
);

  reg [15:0] ptr_inc;
  reg [15:0] ptr_dec;
  reg [15:0] ofs_ext;

  always @* begin
    ptr_inc = ptr_cur + 16'h0001;
    ptr_dec = ptr_cur - 16'h0001;
    ofs_ext = {{10{offset[5]}}, offset};
    eff_addr = ptr_cur;
    ptr_next = ptr_cur;
    if (rel_form) begin
      eff_addr = ptr_cur + ofs_ext;
      ptr_next = ptr_cur;
    end else begin
      case (upd_code)
        `SMX_PU_PRE_INC: begin
          eff_addr = ptr_inc;
          ptr_next = ptr_inc;
        end
        `SMX_PU_PRE_DEC: begin
          eff_addr = ptr_dec;
          ptr_next = ptr_dec;
        end
        `SMX_PU_POST_INC: begin
          eff_addr = ptr_cur;
          ptr_next = ptr_inc;
        end
        default: begin
          eff_addr = ptr_cur;
          ptr_next = ptr_dec;
        end
      endcase
    end
  end

endmodule // smx_ptr_unit

/* dv/smx_exec_asserts.sv */
// assertion checker for the execution datapath
`timescale 1ns/1ps
`include "smx_defs.vh"
module smx_exec_asserts (
  input logic        CLK_SYS,
  input logic        RST_B,
  input logic        OP_VALID,
  input logic [2:0]  OP_CODE,
  input logic        RESULT_TARGET_SEL,
  input logic        PTR_SEL,
  input logic [1:0]  PTR_UPDATE_CODE,
  input logic [7:0]  FILE_RD_DATA,
  input logic [7:0]  MEM_RD_DATA,
  input logic [7:0]  ACC,
  input logic        SHIFT_OUT_FLAG,
  input logic        RESULT_NULL_FLAG,
  input logic        FILE_WR_EN,
  input logic [7:0]  FILE_WR_DATA,
  input logic        MEM_RD_EN,
  input logic [15:0] MEM_RD_ADDR,
  input logic [15:0] POINTER_REG0,
  input logic [15:0] POINTER_REG1,
  input logic        BUSY
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  wire go = OP_VALID && !BUSY;
  wire ld = go && OP_CODE[2] && !OP_CODE[1];
  wire pm = go && OP_CODE == `SMX_OP_LOAD_MOD;
  sequence s_rd;
    MEM_RD_EN && BUSY ##1 !MEM_RD_EN && !BUSY;
  endsequence
  chk_shl_carry:
    assert property (go && OP_CODE == `SMX_OP_SHL |=> SHIFT_OUT_FLAG == $past(FILE_RD_DATA[7]))
    else $error("left shift carry wrong");
  chk_shr_acc:
    assert property (go && OP_CODE == `SMX_OP_SHR && !RESULT_TARGET_SEL |=>
      ACC == {1'b0, $past(FILE_RD_DATA[7:1])} && SHIFT_OUT_FLAG == $past(FILE_RD_DATA[0]))
    else $error("right shift result wrong");
  chk_shl_back:
    assert property (go && OP_CODE == `SMX_OP_SHL && RESULT_TARGET_SEL |=>
      FILE_WR_EN && FILE_WR_DATA == {$past(FILE_RD_DATA[6:0]), 1'b0})
    else $error("shift write back wrong");
  chk_copy_zero:
    assert property (go && OP_CODE == `SMX_OP_COPY |=> RESULT_NULL_FLAG == ($past(FILE_RD_DATA) == 8'h00))
    else $error("copy zero flag wrong");
  chk_load_seq:
    assert property (ld |=> s_rd ##0 (ACC == $past(MEM_RD_DATA) &&
      RESULT_NULL_FLAG == ($past(MEM_RD_DATA) == 8'h00)))
    else $error("load sequence wrong");
  chk_pre_inc:
    assert property (pm && !PTR_SEL && PTR_UPDATE_CODE == `SMX_PU_PRE_INC |=>
      MEM_RD_ADDR == $past(POINTER_REG0) + 16'h0001 && POINTER_REG0 == MEM_RD_ADDR)
    else $error("pre increment wrong");
  chk_post_dec:
    assert property (pm && PTR_SEL && PTR_UPDATE_CODE == `SMX_PU_POST_DEC |=>
      MEM_RD_ADDR == $past(POINTER_REG1) && POINTER_REG1 == $past(POINTER_REG1) - 16'h0001)
    else $error("post decrement wrong");
  chk_rel_keep:
    assert property (go && OP_CODE == `SMX_OP_LOAD_REL |=> $stable(POINTER_REG0) && $stable(POINTER_REG1))
    else $error("relative load moved a pointer");
  chk_load_carry:
    assert property (ld |=> $stable(SHIFT_OUT_FLAG) [*2])
    else $error("load changed carry");
endmodule // smx_exec_asserts
bind smx_exec smx_exec_asserts u_chk (.*);

/* dv/smx_mem_model.sv */
// data memory model answering pointer-indirect reads
`timescale 1ns/1ps
module smx_mem_model (
  input  logic        MEM_RD_EN,
  input  logic [15:0] MEM_RD_ADDR,
  output logic [7:0]  MEM_RD_DATA
);
  // ****************
  // read port
  // ****************
  // word of the pointed address
  // outside a read the inverted word shows, so a mistimed sample cannot pass
  assign MEM_RD_DATA = {8{!MEM_RD_EN}} ^ MEM_RD_ADDR[7:0] ^ MEM_RD_ADDR[15:8];
endmodule // smx_mem_model

/* dv/smx_exec_tb.sv */
// self-checking testbench for the execution datapath
`timescale 1ns/1ps
`include "smx_defs.vh"
module smx_exec_tb;
  logic        CLK_SYS = 0, RST_B = 0, OP_VALID = 0, RESULT_TARGET_SEL = 0, PTR_SEL = 0;
  logic        PTR_WR_EN = 0, PTR_WR_IDX = 0, SHIFT_OUT_FLAG, RESULT_NULL_FLAG;
  logic        FILE_WR_EN, MEM_RD_EN, BUSY;
  logic [2:0]  OP_CODE = 0;
  logic [1:0]  PTR_UPDATE_CODE = 0;
  logic [5:0]  SIGNED_OFFSET = 0;
  logic [7:0]  FILE_RD_DATA = 0, ACC, FILE_WR_DATA, MEM_RD_DATA, r;
  logic [15:0] PTR_WR_DATA = 0, MEM_RD_ADDR, POINTER_REG0, POINTER_REG1, a;
  logic [15:0] p [0:1];
  integer      failures = 0, checks = 0, cyc = 0, i, acc = 0, c = 0, z = 0, n = 0, m = 0, w = 0;
  smx_exec u_dut (.*);
  smx_mem_model u_mem (.*);
  always #5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      failures = failures + 1;
      give_verdict;
    end
  end
  // ****************
  // tasks
  // ****************
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks = checks + 1;
    if (s !== e) begin
      failures = failures + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task pw(input logic x, input logic [15:0] v);
    @(posedge CLK_SYS);
    PTR_WR_EN <= 1;
    PTR_WR_IDX <= x;
    PTR_WR_DATA <= v;
    @(posedge CLK_SYS);
    PTR_WR_EN <= 0;
    p[x] = v;
  endtask
  task run(input logic [2:0] o, input logic d, s, input logic [1:0] u, input logic [5:0] k,
           input logic [7:0] f);
    @(posedge CLK_SYS);
    OP_VALID <= 1;
    OP_CODE <= o;
    RESULT_TARGET_SEL <= d;
    PTR_SEL <= s;
    PTR_UPDATE_CODE <= u;
    SIGNED_OFFSET <= k;
    FILE_RD_DATA <= f;
    @(posedge CLK_SYS);
    n = o != 0 && o < 6;
    m = o == `SMX_OP_LOAD_MOD || o == `SMX_OP_LOAD_REL;
    r = o == `SMX_OP_SHL ? f << 1 : o == `SMX_OP_SHR ? f >> 1 : f;
    if (o == `SMX_OP_SHL || o == `SMX_OP_SHR) c = o == `SMX_OP_SHL ? f[7] : f[0];
    if (m) begin
      a = o[0] ? p[s] + {{10{k[5]}}, k} : u[1] ? p[s] : u[0] ? p[s] - 16'h0001 : p[s] + 16'h0001;
      if (!o[0]) p[s] = u[0] ? p[s] - 16'h0001 : p[s] + 16'h0001;
      r = a[7:0] ^ a[15:8];
      // an op and a pointer write offered during the wait must both be refused
      OP_CODE <= `SMX_OP_COPY;
      FILE_RD_DATA <= ~r;
      PTR_WR_EN <= 1;
      PTR_WR_IDX <= s;
      PTR_WR_DATA <= ~p[s];
      @(posedge CLK_SYS);
      PTR_WR_EN <= 0;
    end
    OP_VALID <= 0;
    if (!d && n) acc = r;
    if (n) z = r == 8'h00;
    if (d && n && !m) w = r;
    #1;
    chk(ACC, acc);
    chk(RESULT_NULL_FLAG, z);
    chk(SHIFT_OUT_FLAG, c);
    chk({POINTER_REG1, POINTER_REG0}, {p[1], p[0]});
    if (m) chk(MEM_RD_ADDR, a);
    else chk({FILE_WR_EN, FILE_WR_DATA}, {d && n, 8'(w)});
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(60));
    p[0] = 0;
    p[1] = 0;
    repeat (8) @(posedge CLK_SYS);
    RST_B <= 1;
    // a few slots offer codes the datapath must ignore
    for (i = 0; i < 60; i = i + 1)
      run(3'(i % 15 == 4 ? 0 : i % 15 == 14 ? 6 + i % 2 : 1 + $urandom % 3),
          1'($urandom), 0, 0, 0, i % 7 == 0 ? 8'h00 : i % 7 == 1 ? 8'h80 : 8'($urandom));
    // mid-run reset: every output must come back to its reset value
    @(posedge CLK_SYS);
    RST_B <= 0;
    repeat (2) @(posedge CLK_SYS);
    RST_B <= 1;
    #1;
    chk({ACC, SHIFT_OUT_FLAG, RESULT_NULL_FLAG, BUSY}, 0);
    chk({FILE_WR_EN, FILE_WR_DATA, MEM_RD_EN}, 0);
    chk({POINTER_REG1, POINTER_REG0}, 0);
    chk(MEM_RD_ADDR, 0);
    acc = 0;
    c = 0;
    z = 0;
    w = 0;
    p[0] = 0;
    p[1] = 0;
    for (i = 0; i < 48; i = i + 1) begin
      pw(i[0], i % 3 == 0 ? 16'hFFFF : i % 3 == 1 ? 16'h0000 : 16'($urandom));
      run(i % 4 == 3 ? `SMX_OP_LOAD_REL : `SMX_OP_LOAD_MOD, 0, i[0], i[3:2],
          i % 8 == 3 ? 6'h20 : 6'h1F, 0);
    end
    give_verdict;
  end
endmodule // smx_exec_tb
